// ===== rtl/vcp_idle_timer.sv
// Purpose: Flags that no kick has arrived for LIMIT clock cycles.
// Assumes: Kick is a single-cycle or level input on the same clock.
// Notes: With the kick tied low it is a delay after reset.
`timescale 1ns/1ps
module vcp_idle_timer
#(
   parameter int unsigned LIMIT = 16
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Activity
   input wire logic i_kick,
   output logic o_idle
);
   localparam int unsigned CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LIM = CW'(LIMIT);
   logic [CW-1:0] cnt_q;

   generate
      if (LIMIT < 1)
      begin : g_chk
         $error("vcp_idle_timer: LIMIT must be at least 1");
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         cnt_q <= '0;
      else if (i_kick)
         cnt_q <= '0;
      else if (cnt_q != LIM)
         cnt_q <= cnt_q + CW'(1);
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_idle <= 1'b0;
      else
         o_idle <= !i_kick && (cnt_q == LIM || cnt_q == LIM - CW'(1));
   end
endmodule

// ===== rtl/vcp_pkg.sv
// Purpose: Constants and types shared by the codec serial port.
// Assumes: System clock 20 MHz; link clock is the codec master clock.
// Notes: Derived cycle counts come from the times and the clock rate.
package vcp_pkg;
   localparam int unsigned WORD_COMP = 8;
   localparam int unsigned WORD_LIN = 16;
   localparam int unsigned LIN_BITS = 13;
   localparam int unsigned ATT_BITS = 3;
   localparam int unsigned SHIFT_W = 16;
   localparam int unsigned BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_MAX = 5'h1F;
   localparam int unsigned SYS_CLK_KHZ = 20000;
   localparam int unsigned POWERUP_US = 500;
   localparam int unsigned POWERUP_CLKS = POWERUP_US * SYS_CLK_KHZ / 1000;
   localparam int unsigned CLK_STOP_NS = 800;
   localparam int unsigned CLK_STOP_CLKS =
      CLK_STOP_NS * SYS_CLK_KHZ / 1000000;
   localparam int unsigned FRAME_CLKS = 144;
   localparam int unsigned STANDBY_FRAMES = 5;
   localparam int unsigned MODE_DET_CLKS = 32;
   typedef enum logic {TX_IDLE, TX_SHIFT} vcp_tx_state_e;
   typedef enum logic {RX_IDLE, RX_SHIFT} vcp_rx_state_e;
endpackage

// ===== rtl/vcp_serial_port.sv
// Purpose: PCM serial port and mode control of a voice-band codec.
// Assumes: Frame syncs, data clocks and serial input are synchronous
//   to the link clock i_mclk; power-down pin is asynchronous.
// Notes: Pins driven three-state as value plus output enable.
// Summary of operation
// - Words travel MSB first; 8 bits companded, 16 bits linear.
// - Fixed mode: transmit bits leave on rising master clock after sync.
// - Fixed mode: receive bits sampled on falling master clock edges.
// - Fixed mode: slot strobe low from first bit until after last bit.
// - Fixed mode: later bits on rising edges, then output floats.
// - Variable mode: bit one at sync rise, next bits on data clock rise.
// - Variable mode: output floats once the transmit sync goes low.
// - A toggling receive data clock selects variable timing.
// - Variable mode: receive bits on falling receive clock while sync high.
// - Variable mode: word repeats while sync high and clock pulses.
// - Outputs float for about four frames after power-up.
// - Outputs float whenever the master clock stops.
// - Power-down pin low floats both transmit outputs.
// - Both syncs low: whole device standby, outputs floating.
// - Only transmit sync pulsing: receive standby, transmit active.
// - Only receive sync pulsing: transmit outputs float within five frames.
// - Transmit and receive run independently at their own sync rates.
// - Linear word: 13-bit sample then attenuation in, zero pad out.
// - Companded receive: last eight bits variable, first eight fixed.
// - Three attenuation bits, eight 3 dB levels, carried in linear words only.
`timescale 1ns/1ps
module vcp_serial_port
   import vcp_pkg::*;
#(
   parameter int unsigned P_POWERUP_CLKS = POWERUP_CLKS,
   parameter int unsigned P_FRAME_CLKS = FRAME_CLKS
)
(
   // System clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Link clock (codec master clock)
   input wire logic i_mclk,
   // Serial pins
   input wire logic i_tx_frame_sync,
   input wire logic i_rx_frame_sync,
   input wire logic i_tx_data_clock,
   input wire logic i_rx_data_clock,
   input wire logic i_serial_data_in,
   input wire logic i_power_down_n,
   output logic o_serial_data_out,
   output logic o_serial_data_out_oe,
   output logic o_tx_slot_strobe_n,
   output logic o_tx_slot_strobe_n_oe,
   // Transmit sample side
   input wire logic i_linear,
   input wire logic [LIN_BITS-1:0] i_tx_sample,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   // Receive sample side
   output logic [LIN_BITS-1:0] o_rx_sample,
   output logic [ATT_BITS-1:0] o_rx_atten,
   output logic o_rx_valid,
   // Status
   output logic o_var_mode,
   output logic o_tx_standby,
   output logic o_rx_standby,
   output logic o_active
);
   generate
      if (P_POWERUP_CLKS < 1 || P_FRAME_CLKS < 1)
      begin : g_chk
         $error("vcp_serial_port: counts must be at least 1");
      end
   endgenerate

   // System domain
   logic pdn_s, pu_done, alive_s, alive_p_q, mclk_stopped, en_q, run_ok;
   logic req_tog_q, ack_s, rx_tog_s, rx_tog_p_q;
   logic [LIN_BITS-1:0] tx_hold_q;
   logic [2:0] stat_s;
   // Link domain
   logic en_l, lin_l, req_l, req_l_q, ack_tog_q, alive_q, var_l;
   logic fsx_q, tx_data_clock_q, fsr_p_q, rx_data_clock_n_q, rx_arm_q;
   logic tx_idle_l, rx_idle_l, fixed_l;
   logic tx_start, rx_start, rx_done, bit_ev;
   logic tx_oe_q, tx_stb_q, rx_tog_q, rx_lin_q;
   logic [LIN_BITS-1:0] tx_word_q;
   logic [SHIFT_W-1:0] tx_sh_q, load_word, rx_sh_q, rx_sh_nx, rx_word_q;
   logic [SHIFT_W-1:0] rx_done_word;
   logic [BIT_CNT_W-1:0] tx_cnt_q, rx_cnt_q, nbits;
   vcp_tx_state_e tx_state_q;
   vcp_rx_state_e rx_state_q;

   vcp_sync #(.W(1)) u_pdn_sync (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_d(i_power_down_n), .o_q(pdn_s));
   vcp_sync #(.W(1)) u_alive_sync (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_d(alive_q), .o_q(alive_s));
   vcp_sync #(.W(1)) u_ack_sync (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_d(ack_tog_q), .o_q(ack_s));
   vcp_sync #(.W(1)) u_rx_sync (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_d(rx_tog_q), .o_q(rx_tog_s));
   vcp_sync #(.W(3)) u_stat_sync (.i_clk(i_clk), .i_rst_b(i_rst_b),
      .i_d({var_l, tx_idle_l, rx_idle_l}), .o_q(stat_s));

   // Hold-off after power-up
   vcp_idle_timer #(.LIMIT(P_POWERUP_CLKS)) u_powerup (.i_clk(i_clk),
      .i_rst_b(i_rst_b), .i_kick(1'b0), .o_idle(pu_done));
   // Master clock watchdog
   vcp_idle_timer #(.LIMIT(CLK_STOP_CLKS)) u_clkstop (.i_clk(i_clk),
      .i_rst_b(i_rst_b), .i_kick(alive_s ^ alive_p_q),
      .o_idle(mclk_stopped));
   // Restart hold; link side must first drop a slot cut by the stop
   vcp_idle_timer #(.LIMIT(P_POWERUP_CLKS)) u_restart (.i_clk(i_clk),
      .i_rst_b(i_rst_b), .i_kick(mclk_stopped), .o_idle(run_ok));

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         en_q <= 1'b0;
      else
         en_q <= pdn_s && pu_done && !mclk_stopped
                 && run_ok;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         alive_p_q <= 1'b0;
         rx_tog_p_q <= 1'b0;
      end
      else
      begin
         alive_p_q <= alive_s;
         rx_tog_p_q <= rx_tog_s;
      end
   end

   // Transmit sample handoff; link copies tx_hold_q once req seen
   assign o_tx_ready = (req_tog_q == ack_s);

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         req_tog_q <= 1'b0;
         tx_hold_q <= '0;
      end
      else if (i_tx_valid && o_tx_ready)
      begin
         req_tog_q <= !req_tog_q;
         tx_hold_q <= i_tx_sample;
      end
   end

   // Receive word presentation
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_rx_sample <= '0;
         o_rx_atten <= '0;
         o_rx_valid <= 1'b0;
      end
      else
      begin
         o_rx_valid <= rx_tog_s ^ rx_tog_p_q;
         if (rx_tog_s ^ rx_tog_p_q)
         begin
            if (rx_lin_q)
            begin
               o_rx_sample <= rx_word_q[SHIFT_W-1 -: LIN_BITS];
               o_rx_atten <= rx_word_q[ATT_BITS-1:0];
            end
            else
            begin
               o_rx_sample <= LIN_BITS'(rx_word_q[WORD_COMP-1:0]);
               o_rx_atten <= '0;
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_var_mode <= 1'b0;
         o_tx_standby <= 1'b0;
         o_rx_standby <= 1'b0;
         o_active <= 1'b0;
      end
      else
      begin
         o_var_mode <= stat_s[2];
         o_tx_standby <= stat_s[1];
         o_rx_standby <= stat_s[0];
         o_active <= en_q;
      end
   end

   // Pins float unless enabled and in slot
   assign o_serial_data_out = tx_sh_q[SHIFT_W-1];
   assign o_serial_data_out_oe = tx_oe_q && en_q;
   assign o_tx_slot_strobe_n = !tx_stb_q;
   assign o_tx_slot_strobe_n_oe = tx_stb_q && en_q;

   // Link domain
   vcp_sync #(.W(3)) u_link_sync (.i_clk(i_mclk), .i_rst_b(i_rst_b),
      .i_d({en_q, i_linear, req_tog_q}), .o_q({en_l, lin_l, req_l}));
   // Receive clock held high selects fixed timing
   vcp_idle_timer #(.LIMIT(MODE_DET_CLKS)) u_mode (.i_clk(i_mclk),
      .i_rst_b(i_rst_b), .i_kick(!i_rx_data_clock),
      .o_idle(fixed_l));
   assign var_l = !fixed_l;
   vcp_idle_timer #(.LIMIT(P_FRAME_CLKS * STANDBY_FRAMES)) u_txsb
      (.i_clk(i_mclk), .i_rst_b(i_rst_b),
      .i_kick(i_tx_frame_sync && !fsx_q), .o_idle(tx_idle_l));
   vcp_idle_timer #(.LIMIT(P_FRAME_CLKS * STANDBY_FRAMES)) u_rxsb
      (.i_clk(i_mclk), .i_rst_b(i_rst_b),
      .i_kick(i_rx_frame_sync && !fsr_p_q), .o_idle(rx_idle_l));

   assign nbits = lin_l ? BIT_CNT_W'(WORD_LIN) : BIT_CNT_W'(WORD_COMP);
   assign load_word = lin_l ? {tx_word_q, {ATT_BITS{1'b0}}}
                            : {tx_word_q[WORD_COMP-1:0], 8'h00};
   assign tx_start = (tx_state_q == TX_IDLE) && en_l
                     && i_tx_frame_sync && !fsx_q;

   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         alive_q <= 1'b0;
         fsx_q <= 1'b0;
         tx_data_clock_q <= 1'b0;
         fsr_p_q <= 1'b0;
         req_l_q <= 1'b0;
         ack_tog_q <= 1'b0;
         tx_word_q <= '0;
      end
      else
      begin
         alive_q <= !alive_q;
         fsx_q <= i_tx_frame_sync;
         tx_data_clock_q <= i_tx_data_clock;
         fsr_p_q <= i_rx_frame_sync;
         req_l_q <= req_l;
         if (req_l != req_l_q)
         begin
            tx_word_q <= tx_hold_q;
            ack_tog_q <= req_l;
         end
      end
   end

   // Transmit shifter
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         tx_state_q <= TX_IDLE;
         tx_sh_q <= '0;
         tx_cnt_q <= '0;
         tx_oe_q <= 1'b0;
         tx_stb_q <= 1'b0;
      end
      else
      begin
         case (tx_state_q)
            TX_IDLE:
               if (tx_start)
               begin
                  tx_sh_q <= load_word;
                  tx_cnt_q <= BIT_CNT_W'(1);
                  tx_oe_q <= 1'b1;
                  tx_stb_q <= fixed_l;
                  tx_state_q <= TX_SHIFT;
               end
            TX_SHIFT:
               if (!en_l || (var_l && !i_tx_frame_sync)
                   || (fixed_l && tx_cnt_q == nbits))
               begin
                  tx_oe_q <= 1'b0;
                  tx_stb_q <= 1'b0;
                  tx_state_q <= TX_IDLE;
               end
               else if (fixed_l || (i_tx_data_clock && !tx_data_clock_q))
               begin
                  if (tx_cnt_q == nbits)
                  begin
                     tx_sh_q <= load_word;
                     tx_cnt_q <= BIT_CNT_W'(1);
                  end
                  else
                  begin
                     tx_sh_q <= {tx_sh_q[SHIFT_W-2:0], 1'b0};
                     tx_cnt_q <= tx_cnt_q + BIT_CNT_W'(1);
                  end
               end
            default:
               tx_state_q <= TX_IDLE;
         endcase
      end
   end

   // Receive shifter on falling master clock
   assign bit_ev = fixed_l || (!i_rx_data_clock && rx_data_clock_n_q);
   assign rx_start = (rx_state_q == RX_IDLE) && en_l && rx_arm_q
                     && i_rx_frame_sync && bit_ev;
   assign rx_sh_nx = {rx_sh_q[SHIFT_W-2:0], i_serial_data_in};
   always_comb
   begin
      rx_done = 1'b0;
      rx_done_word = rx_sh_nx;
      if (rx_state_q == RX_SHIFT && en_l)
      begin
         if (var_l && !lin_l && !i_rx_frame_sync)
         begin
            rx_done = (rx_cnt_q >= BIT_CNT_W'(WORD_COMP));
            rx_done_word = rx_sh_q;
         end
         else if (i_rx_frame_sync || fixed_l)
            rx_done = bit_ev && (lin_l || fixed_l)
                      && (rx_cnt_q + BIT_CNT_W'(1) == nbits);
      end
   end

   always_ff @(negedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rx_state_q <= RX_IDLE;
         rx_sh_q <= '0;
         rx_cnt_q <= '0;
         rx_arm_q <= 1'b0;
         rx_data_clock_n_q <= 1'b0;
         rx_word_q <= '0;
         rx_lin_q <= 1'b0;
         rx_tog_q <= 1'b0;
      end
      else
      begin
         rx_data_clock_n_q <= i_rx_data_clock;
         if (!i_rx_frame_sync)
            rx_arm_q <= 1'b1;
         else if (rx_start)
            rx_arm_q <= 1'b0;
         if (rx_done)
         begin
            rx_word_q <= lin_l ? rx_done_word
                               : {8'h00, rx_done_word[WORD_COMP-1:0]};
            rx_lin_q <= lin_l;
            rx_tog_q <= !rx_tog_q;
         end
         case (rx_state_q)
            RX_IDLE:
               if (rx_start)
               begin
                  rx_sh_q <= rx_sh_nx;
                  rx_cnt_q <= BIT_CNT_W'(1);
                  rx_state_q <= RX_SHIFT;
               end
            RX_SHIFT:
               if (rx_done || !en_l || (var_l && !i_rx_frame_sync))
                  rx_state_q <= RX_IDLE;
               else if (bit_ev)
               begin
                  rx_sh_q <= rx_sh_nx;
                  if (rx_cnt_q != BIT_CNT_MAX)
                     rx_cnt_q <= rx_cnt_q + BIT_CNT_W'(1);
               end
            default:
               rx_state_q <= RX_IDLE;
         endcase
      end
   end

   // Checks
   sequence s_fix_comp_tx;
      tx_start && fixed_l && !lin_l;
   endsequence
   sequence s_fix_comp_rx;
      rx_start && fixed_l && !lin_l;
   endsequence

   property p_fix_slot;
      @(posedge i_mclk) disable iff (!i_rst_b || !en_l)
      s_fix_comp_tx |=> (tx_oe_q && tx_stb_q)[*8] ##1 !tx_oe_q;
   endproperty
   a_fix_slot: assert property (p_fix_slot)
      else $error("fixed transmit slot length wrong");

   property p_first_bit;
      @(posedge i_mclk) disable iff (!i_rst_b)
      tx_start |=> tx_sh_q[SHIFT_W-1] == $past(load_word[SHIFT_W-1]);
   endproperty
   a_first_bit: assert property (p_first_bit)
      else $error("first transmit bit is not the MSB");

   property p_var_release;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (var_l && tx_oe_q && !i_tx_frame_sync) |=> !tx_oe_q;
   endproperty
   a_var_release: assert property (p_var_release)
      else $error("output still driven after sync low");

   property p_repeat;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (tx_state_q == TX_SHIFT && var_l && en_l && i_tx_frame_sync
       && i_tx_data_clock && !tx_data_clock_q && tx_cnt_q == nbits)
      |=> tx_oe_q && tx_cnt_q == BIT_CNT_W'(1);
   endproperty
   a_repeat: assert property (p_repeat)
      else $error("word not repeated in variable mode");

   property p_tx_standby;
      @(posedge i_mclk) disable iff (!i_rst_b)
      (tx_idle_l && !i_tx_frame_sync) |-> !tx_oe_q && !tx_stb_q;
   endproperty
   a_tx_standby: assert property (p_tx_standby)
      else $error("transmit outputs active in standby");

   property p_fix_rx;
      @(negedge i_mclk) disable iff (!i_rst_b)
      s_fix_comp_rx ##1 (en_l && fixed_l && !lin_l)[*7] |-> rx_done;
   endproperty
   a_fix_rx: assert property (p_fix_rx)
      else $error("fixed companded word not taken in eight bits");

   property p_pdn;
      @(posedge i_clk) disable iff (!i_rst_b)
      !pdn_s |=> !o_serial_data_out_oe && !o_tx_slot_strobe_n_oe;
   endproperty
   a_pdn: assert property (p_pdn)
      else $error("outputs driven in power-down");

   property p_powerup;
      @(posedge i_clk) disable iff (!i_rst_b)
      !pu_done |-> !o_serial_data_out_oe && !o_tx_slot_strobe_n_oe;
   endproperty
   a_powerup: assert property (p_powerup)
      else $error("outputs driven during power-up hold");

   property p_clkstop;
      @(posedge i_clk) disable iff (!i_rst_b)
      mclk_stopped |=> !en_q ##1 !o_serial_data_out_oe;
   endproperty
   a_clkstop: assert property (p_clkstop)
      else $error("outputs driven with master clock stopped");
endmodule

// ===== rtl/vcp_sync.sv
// Purpose: Two-flop synchroniser for levels and toggles.
// Assumes: Input is a level or slow toggle from another domain.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module vcp_sync
#(
   parameter int unsigned W = 1
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Data
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q;

   generate
      if (W < 1)
      begin : g_chk
         $error("vcp_sync: W must be at least 1");
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         meta_q <= '0;
         o_q <= '0;
      end
      else
      begin
         meta_q <= i_d;
         o_q <= meta_q;
      end
   end
endmodule

// ===== testbench/test_voice_codec_pcm_serial_port.sv
// Purpose: Self-checking bench of the codec serial port.
// Assumes: Short power-up hold and frame length parameters.
// Notes: Scenarios run in order; each leaves the port enabled.
`timescale 1ns/1ps
module test_voice_codec_pcm_serial_port;
   logic clk = 1'b0;
   logic mclk = 1'b0;
   logic mclk_run = 1'b1;
   logic rst_b = 1'b0;
   logic power_down_n = 1'b0;
   logic linear = 1'b0;
   logic tx_valid = 1'b0;
   logic [vcp_pkg::LIN_BITS-1:0] tx_sample = 13'h0000;
   logic [vcp_pkg::LIN_BITS-1:0] rx_sample;
   logic [vcp_pkg::ATT_BITS-1:0] rx_atten;
   wire logic fs_tx, fs_rx, dck_tx, dck_rx, sdi, sdo, sdo_oe, stb, stb_oe;
   wire logic ready, rx_valid, var_mode, tx_sb, rx_sb, active;
   // Strobe line has a pull-up
   wire logic stb_line = stb_oe ? stb : 1'b1;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int rx_cnt = 0;
   initial
   begin
      forever #25 clk = ~clk;
   end
   initial
   begin
      #13;
      forever #80 mclk = mclk_run ? ~mclk : mclk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         num_errors++;
         final_report();
      end
      if (rx_valid === 1'b1)
         rx_cnt++;
   end
   vcp_serial_port #(.P_POWERUP_CLKS(20), .P_FRAME_CLKS(16)) vcp_serial_port_i
   (
      .i_clk(clk), .i_rst_b(rst_b), .i_mclk(mclk),
      .i_tx_frame_sync(fs_tx), .i_rx_frame_sync(fs_rx),
      .i_tx_data_clock(dck_tx), .i_rx_data_clock(dck_rx),
      .i_serial_data_in(sdi), .i_power_down_n(power_down_n),
      .o_serial_data_out(sdo), .o_serial_data_out_oe(sdo_oe),
      .o_tx_slot_strobe_n(stb), .o_tx_slot_strobe_n_oe(stb_oe),
      .i_linear(linear), .i_tx_sample(tx_sample), .i_tx_valid(tx_valid),
      .o_tx_ready(ready), .o_rx_sample(rx_sample), .o_rx_atten(rx_atten),
      .o_rx_valid(rx_valid), .o_var_mode(var_mode),
      .o_tx_standby(tx_sb), .o_rx_standby(rx_sb), .o_active(active)
   );
   vcp_dsp_model vcp_dsp_model_i
   (
      .i_mclk(mclk), .o_tx_frame_sync(fs_tx), .o_rx_frame_sync(fs_rx),
      .o_tx_data_clock(dck_tx), .o_rx_data_clock(dck_rx),
      .o_serial_data_in(sdi), .i_serial_data_out(sdo),
      .i_serial_data_out_oe(sdo_oe), .i_strobe_line(stb_line)
   );
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp,
      input string what);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what,
            got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp,
      input string what);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: %s got %b", $time, what, got);
      end
   endtask
   task automatic load(input logic [12:0] s);
      @(posedge clk) #2;
      tx_sample = s;
      tx_valid = 1'b1;
      repeat (40) if (ready !== 1'b1) @(posedge clk) #2;
      @(posedge clk) #2;
      tx_valid = 1'b0;
      repeat (40) if (ready !== 1'b1) @(posedge clk) #2;
      check_bit(ready, 1'b1, "sample handoff");
   endtask
   task automatic wait_active();
      repeat (100) if (active !== 1'b1) @(posedge clk) #2;
      check_bit(active, 1'b1, "outputs enabled");
      repeat (4) @(posedge mclk);
   endtask
   task automatic frame_ok(input logic [15:0] exp, input string what);
      check_bit(vcp_dsp_model_i.ok, 1'b1, what);
      check_word(vcp_dsp_model_i.got, exp, what);
   endtask
   task automatic t_powerup();
      repeat (15) @(posedge clk) #2;
      check_bit(sdo_oe | stb_oe | active, 1'b0, "power-up hold");
      wait_active();
      repeat (40) @(posedge mclk);
      check_bit(var_mode, 1'b0, "fixed timing");
   endtask
   task automatic t_fixed();
      logic [12:0] s;
      int c0;
      c0 = rx_cnt;
      load(13'h00A5);
      vcp_dsp_model_i.fixed_frame(1'b1, 1'b1, 8, 1'b1, 16'h3C00);
      repeat (6) @(posedge clk) #2;
      frame_ok(16'h00A5, "companded out");
      check_word({rx_atten, rx_sample}, 16'h003C, "comp in");
      linear = 1'b1;
      for (int a = 0; a < 8; a++)
      begin
         s = 13'h1234 + 13'(a);
         load(s);
         vcp_dsp_model_i.fixed_frame(1'b1, 1'b1, 16, 1'b1,
            {13'h0F0F ^ 13'(a), 3'(a)});
         repeat (6) @(posedge clk) #2;
         frame_ok({s, 3'h0}, "linear out");
         check_word({rx_atten, rx_sample}, {3'(a), 13'h0F0F ^ 13'(a)},
            "linear in");
      end
      check_word(16'(rx_cnt - c0), 16'h0009, "received words");
      linear = 1'b0;
   endtask
   task automatic t_standby();
      repeat (100) @(posedge mclk);
      check_word({12'h000, tx_sb, rx_sb, sdo_oe, stb_oe}, 16'h000C,
         "full standby");
      repeat (9) vcp_dsp_model_i.fixed_frame(1'b0, 1'b1, 8, 1'b0, 16'h5A00);
      check_bit(vcp_dsp_model_i.ok, 1'b1, "tx standby float");
      check_word({14'h0000, tx_sb, rx_sb}, 16'h0002, "tx standby");
      repeat (9) vcp_dsp_model_i.fixed_frame(1'b1, 1'b0, 8, 1'b1, 16'h0000);
      frame_ok(16'h003B, "rx standby out");
      check_word({14'h0000, tx_sb, rx_sb}, 16'h0001, "rx standby");
   endtask
   task automatic t_pdn();
      @(posedge clk) #2;
      power_down_n = 1'b0;
      repeat (6) @(posedge clk) #2;
      check_bit(active, 1'b0, "power down");
      vcp_dsp_model_i.fixed_frame(1'b1, 1'b1, 8, 1'b0, 16'h0000);
      check_bit(vcp_dsp_model_i.ok, 1'b1, "power down float");
      @(posedge clk) #2;
      power_down_n = 1'b1;
      wait_active();
      vcp_dsp_model_i.fixed_frame(1'b1, 1'b1, 8, 1'b1, 16'h0000);
      frame_ok(16'h003B, "after power down");
   endtask
   task automatic t_clkstop();
      fork
         vcp_dsp_model_i.fixed_frame(1'b1, 1'b1, 8, 1'b1, 16'h0000);
      join_none
      repeat (4) @(posedge mclk);
      #10;
      check_bit(sdo_oe, 1'b1, "driving before stop");
      mclk_run = 1'b0;
      repeat (24) @(posedge clk) #2;
      check_bit(sdo_oe | stb_oe, 1'b0, "clock stopped");
      mclk_run = 1'b1;
      wait fork;
      wait_active();
   endtask
   task automatic t_variable();
      @(posedge clk) #2;
      vcp_dsp_model_i.var_mode = 1'b1;
      repeat (40) @(posedge mclk);
      check_bit(var_mode, 1'b1, "variable timing");
      load(13'h0096);
      repeat (2) vcp_dsp_model_i.var_frame(2, 8, 10, 16'h9600, 16'hB5C0);
      repeat (6) @(posedge clk) #2;
      check_bit(vcp_dsp_model_i.ok, 1'b1, "repeat");
      check_word({rx_atten, rx_sample}, 16'h00D7, "last eight");
      linear = 1'b1;
      load(13'h1ABC);
      vcp_dsp_model_i.var_frame(1, 16, 16, 16'hD5E0, 16'h2469);
      repeat (6) @(posedge clk) #2;
      check_bit(vcp_dsp_model_i.ok, 1'b1, "lin var out");
      check_word({rx_atten, rx_sample}, 16'h248D, "lin var in");
      linear = 1'b0;
   endtask
   task automatic final_report();
      if (num_errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk) #2;
      power_down_n = 1'b1;
      repeat (8) @(posedge clk) #2;
      rst_b = 1'b1;
      t_powerup();
      t_fixed();
      t_standby();
      t_pdn();
      t_clkstop();
      t_variable();
      final_report();
   end
endmodule

// ===== testbench/vcp_dsp_model.sv
// Purpose: Signal processor model driving the codec frame and data lines.
// Assumes: Lines change 5 ns after a rising master clock edge.
// Notes: Tasks are called from the bench; ok drops on a bad pin state.
`timescale 1ns/1ps
module vcp_dsp_model
(
   // Link clock
   input wire logic i_mclk,
   // Lines toward the codec
   output logic o_tx_frame_sync,
   output logic o_rx_frame_sync,
   output logic o_tx_data_clock,
   output logic o_rx_data_clock,
   output logic o_serial_data_in,
   // Lines from the codec
   input wire logic i_serial_data_out,
   input wire logic i_serial_data_out_oe,
   input wire logic i_strobe_line
);
   logic var_mode = 1'b0;
   logic dclk = 1'b0;
   logic ok = 1'b1;
   logic [15:0] got = 16'h0000;
   initial
   begin
      o_tx_frame_sync = 1'b0;
      o_rx_frame_sync = 1'b0;
      o_serial_data_in = 1'b0;
   end
   // Data clock at half the master rate, edges tied to the master clock
   always @(posedge i_mclk)
   begin
      #5;
      dclk = ~dclk;
   end
   assign o_rx_data_clock = var_mode ? dclk : 1'b1;
   assign o_tx_data_clock = var_mode ? dclk : 1'b0;
   task automatic fixed_frame(input logic tx, input logic rx, input int n,
      input logic on, input logic [15:0] word);
      logic act;
      ok = 1'b1;
      got = 16'h0000;
      @(posedge i_mclk);
      #5;
      o_tx_frame_sync = tx;
      o_rx_frame_sync = rx;
      o_serial_data_in = word[15];
      for (int k = 0; k <= n + 1; k++)
      begin
         @(negedge i_mclk);
         act = on && k >= 1 && k <= n;
         if (act)
            got = {got[14:0], i_serial_data_out};
         if (i_serial_data_out_oe !== act || i_strobe_line !== !act)
            ok = 1'b0;
         @(posedge i_mclk);
         #5;
         o_tx_frame_sync = 1'b0;
         o_rx_frame_sync = 1'b0;
         // Released line toggles every bit, starting from the inverse of its last bit
         o_serial_data_in = (k + 1 < n) ? word[14 - k] : ~o_serial_data_in;
      end
   endtask
   task automatic var_frame(input int slots, input int n, input int rbits,
      input logic [15:0] txw, input logic [15:0] rxw);
      ok = 1'b1;
      @(posedge dclk);
      o_tx_frame_sync = 1'b1;
      o_rx_frame_sync = 1'b1;
      for (int i = 0; i < slots * n; i++)
      begin
         o_serial_data_in = (i < rbits) ? rxw[15 - i] : ~o_serial_data_in;
         @(negedge dclk);
         if (i_serial_data_out_oe !== 1'b1 || i_strobe_line !== 1'b1 ||
            i_serial_data_out !== txw[15 - i % n])
            ok = 1'b0;
         @(posedge dclk);
         if (i + 1 == rbits)
            o_rx_frame_sync = 1'b0;
      end
      o_tx_frame_sync = 1'b0;
      repeat (2) @(negedge i_mclk);
      if (i_serial_data_out_oe !== 1'b0)
         ok = 1'b0;
   endtask
endmodule
